// ---- hdl/fbw_host.sv ----
`timescale 1ns/10ps
module fbw_host import fbw_pkg::*; #(
    parameter int ABORT_CYCLES = ABORT_CYC,
    parameter int WC_CYCLES    = WC_CYC,
    parameter int ERASE_CYCLES = ERASE_CYC,
    parameter int VPS_CYCLES   = VPS_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire fbw_cmd_t          req_cmd,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_data,
    input  wire logic              abort_req,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    output logic                   rsp_aborted,
    output fbw_pins_t              pins,
    output logic [DATA_W-1:0]      byte_data_o,
    output logic                   byte_data_oe,
    input  wire logic [DATA_W-1:0] byte_data_i
);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_VPS   = 4'h1,
        ST_SETUP = 4'h3,
        ST_PULSE = 4'h2,
        ST_HOLD  = 4'h6,
        ST_WAIT  = 4'h7,
        ST_DONE  = 4'h5,
        ST_READ  = 4'h4,
        ST_ABORT = 4'hc
    } fbw_st_t;

    fbw_st_t           st_reg, st_next;
    logic [CNT_W-1:0]  cnt_reg, cnt_next;
    fbw_cmd_t          cmd_reg, cmd_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] data_reg, data_next;
    logic              pass_reg, pass_next;
    logic              abrt_reg, abrt_next;
    logic [DATA_W-1:0] rdat_reg, rdat_next;
    fbw_pins_t         pins_reg, pins_next;
    logic              oe_reg, oe_next;
    logic              in_window;

    assign req_ready    = (st_reg == ST_IDLE);
    assign rsp_valid    = (st_reg == ST_DONE);
    assign rsp_data     = rdat_reg;
    assign rsp_aborted  = abrt_reg;
    assign pins         = pins_reg;
    assign byte_data_o  = data_reg;
    assign byte_data_oe = oe_reg;
    // Closes early so the abort write still latches inside the device window
    assign in_window = (st_reg == ST_WAIT) && (cmd_reg == FBW_CMD_SERASE)
                       && !pass_reg && (int'(cnt_reg) < ABORT_CYCLES - ABORT_LAT_CYC);

    always_comb begin
        st_next   = st_reg;
        cnt_next  = cnt_reg + 1'b1;
        cmd_next  = cmd_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        pass_next = pass_reg;
        abrt_next = abrt_reg;
        rdat_next = rdat_reg;
        pins_next = pins_reg;
        oe_next   = oe_reg;
        unique case (st_reg)
            ST_IDLE: begin
                cnt_next = '0;
                pins_next.chip_sel_n  = 1'b1;
                pins_next.out_drv_n   = 1'b1;
                pins_next.wr_strobe_n = 1'b1;
                oe_next               = 1'b0;
                if (req_valid) begin
                    cmd_next  = req_cmd;
                    addr_next = req_addr;
                    data_next = req_data;
                    pass_next = 1'b0;
                    abrt_next = 1'b0;
                    pins_next.byte_addr = req_addr;
                    if (req_cmd == FBW_CMD_READ) begin
                        pins_next.programming_level = 1'b0;
                        pins_next.chip_sel_n        = 1'b0;
                        pins_next.out_drv_n         = 1'b0;
                        st_next = ST_READ;
                    end else if (req_cmd == FBW_CMD_WRITE && req_data == ERASE_BYTE) begin
                        st_next = ST_DONE;
                    end else begin
                        // Chip erase select pass first with level low
                        pins_next.programming_level = (req_cmd != FBW_CMD_CERASE);
                        if (req_cmd != FBW_CMD_WRITE) data_next = ERASE_BYTE;
                        st_next = ST_VPS;
                    end
                end
            end
            ST_READ: begin
                if (cnt_reg == CNT_W'(RD_CYC)) begin
                    rdat_next = byte_data_i;
                    pins_next.chip_sel_n = 1'b1;
                    pins_next.out_drv_n  = 1'b1;
                    st_next = ST_DONE;
                end
            end
            ST_VPS: begin
                if (cnt_reg >= CNT_W'(VPS_CYCLES)) begin
                    // Write mode: select low, drive high
                    pins_next.chip_sel_n = 1'b0;
                    pins_next.out_drv_n  = 1'b1;
                    oe_next  = 1'b1;
                    cnt_next = '0;
                    st_next  = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // Address settled before the later falling edge
                if (cnt_reg >= CNT_W'(AS_CYC)) begin
                    pins_next.wr_strobe_n = 1'b0;
                    cnt_next = '0;
                    st_next  = ST_PULSE;
                end
            end
            ST_PULSE: begin
                // Pulse width well above glitch filter
                if (cnt_reg >= CNT_W'(WP_CYC + DS_CYC)) begin
                    // Data held past the early rising edge
                    pins_next.wr_strobe_n = 1'b1;
                    cnt_next = '0;
                    st_next  = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_reg >= CNT_W'(AH_CYC)) begin
                    pins_next.chip_sel_n = 1'b1;
                    oe_next  = 1'b0;
                    cnt_next = '0;
                    st_next  = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Abort by a further write inside the window
                if (in_window && abort_req) begin
                    abrt_next = 1'b1;
                    data_next = 8'h00;
                    cnt_next  = '0;
                    st_next   = ST_ABORT;
                // Device self-times; host waits out the cycle
                // Byte write waited for the full cycle
                end else if (cnt_reg >= CNT_W'(cmd_reg == FBW_CMD_WRITE ? WC_CYCLES
                             : ERASE_CYCLES + (cmd_reg == FBW_CMD_SERASE ? ABORT_CYCLES : 0))) begin
                    if (cmd_reg == FBW_CMD_CERASE && !pass_reg) begin
                        // Second pass with level high runs the chip erase
                        pass_next = 1'b1;
                        pins_next.programming_level = 1'b1;
                        cnt_next = '0;
                        st_next  = ST_VPS;
                    end else begin
                        pins_next.programming_level = 1'b0;
                        st_next = ST_DONE;
                    end
                end
            end
            ST_ABORT: begin
                // Abort write reuses the strobe sequence, then waits briefly
                pins_next.chip_sel_n = 1'b0;
                pins_next.byte_addr  = addr_reg;
                oe_next  = 1'b1;
                pass_next = 1'b1;
                cnt_next = '0;
                st_next  = ST_SETUP;
            end
            ST_DONE: begin
                if (abrt_reg && pass_reg && cmd_reg == FBW_CMD_SERASE) begin
                    pins_next.programming_level = 1'b0;
                end
                st_next = ST_IDLE;
            end
            default: st_next = ST_IDLE;
        endcase
        // Aborted erase ends after its abort write, not after erase time
        if (st_reg == ST_WAIT && abrt_reg && cnt_reg >= CNT_W'(WC_CYCLES)) begin
            pins_next.programming_level = 1'b0;
            st_next = ST_DONE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg   <= ST_IDLE;
            cnt_reg  <= '0;
            cmd_reg  <= FBW_CMD_READ;
            addr_reg <= '0;
            data_reg <= '0;
            pass_reg <= 1'b0;
            abrt_reg <= 1'b0;
            rdat_reg <= '0;
            pins_reg <= '{chip_sel_n: 1'b1, out_drv_n: 1'b1, wr_strobe_n: 1'b1,
                          programming_level: 1'b0, byte_addr: '0};
            oe_reg   <= 1'b0;
        end else begin
            st_reg   <= st_next;
            cnt_reg  <= cnt_next;
            cmd_reg  <= cmd_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            pass_reg <= pass_next;
            abrt_reg <= abrt_next;
            rdat_reg <= rdat_next;
            pins_reg <= pins_next;
            oe_reg   <= oe_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_strobe_fall;
        $fell(pins.wr_strobe_n);
    endsequence
    sequence s_strobe_low_min;
        !pins.wr_strobe_n [*5];
    endsequence

    property p_pulse_width;
        @(posedge clk) disable iff (rst) s_strobe_fall |-> s_strobe_low_min;
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("strobe too short");
    property p_write_mode;
        @(posedge clk) disable iff (rst)
            !pins.wr_strobe_n |-> (!pins.chip_sel_n && pins.out_drv_n && byte_data_oe);
    endproperty
    a_write_mode: assert property (p_write_mode) else $error("bad write mode");
    property p_level_up;
        @(posedge clk) disable iff (rst)
            s_strobe_fall |-> $past(pins.programming_level, 1) || cmd_reg == FBW_CMD_CERASE;
    endproperty
    a_level_up: assert property (p_level_up) else $error("write without level");
    property p_read_pins;
        @(posedge clk) disable iff (rst)
            st_reg == ST_READ |-> (!pins.chip_sel_n && !pins.out_drv_n && pins.wr_strobe_n
                                   && !byte_data_oe);
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("bad read pins");
    property p_erase_ff;
        @(posedge clk) disable iff (rst)
            (s_strobe_fall and cmd_reg != FBW_CMD_WRITE && !abrt_reg)
            |-> byte_data_o == ERASE_BYTE;
    endproperty
    a_erase_ff: assert property (p_erase_ff) else $error("erase data not ff");
    property p_no_ff_write;
        @(posedge clk) disable iff (rst)
            s_strobe_fall and cmd_reg == FBW_CMD_WRITE |-> byte_data_o != ERASE_BYTE;
    endproperty
    a_no_ff_write: assert property (p_no_ff_write) else $error("ff byte written");
    property p_busy;
        @(posedge clk) disable iff (rst)
            st_reg == ST_WAIT |-> !req_ready && pins.wr_strobe_n && pins.chip_sel_n;
    endproperty
    a_busy: assert property (p_busy) else $error("strobe while busy");
    property p_addr_stable;
        @(posedge clk) disable iff (rst)
            !pins.wr_strobe_n |-> $stable(pins.byte_addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved");
endmodule // fbw_host

// ---- hdl/fbw_pkg.sv ----
package fbw_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W        = 17;
    localparam int DATA_W        = 8;
    localparam int COL_W         = 10;
    localparam int SECTORS       = 128;
    localparam int SECTOR_BYTES  = 1024;
    localparam logic [7:0] ERASE_BYTE = 8'hff;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 50;
    localparam int CLK_NS        = 20;
    localparam int GLITCH_NS     = 20;
    localparam int WP_NS         = 100;
    localparam int AS_NS         = 20;
    localparam int DS_NS         = 50;
    localparam int AH_NS         = 100;
    localparam int READ_NS       = 300;
    localparam int VPS_US        = 2;
    localparam int WC_US         = 150;
    localparam int ABORT_US      = 100;
    localparam int ERASE_MS      = 500;
    localparam int WP_CYC   = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int AS_CYC   = (AS_NS + CLK_NS - 1) / CLK_NS;
    localparam int DS_CYC   = (DS_NS + CLK_NS - 1) / CLK_NS;
    localparam int AH_CYC   = (AH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_CYC   = (READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int VPS_CYC  = VPS_US * CLK_MHZ;
    localparam int WC_CYC   = WC_US * CLK_MHZ;
    localparam int ABORT_CYC = ABORT_US * CLK_MHZ;
    // Cycles from the device latching the FF byte to it latching the abort write
    localparam int ABORT_LAT_CYC = AH_CYC + AS_CYC + WP_CYC + DS_CYC + 5;
    localparam int ERASE_CYC = ERASE_MS * 1000 * CLK_MHZ;
    localparam int CNT_W    = 26;

    // ------------------------------------------------------------
    // Commands and pin bundle
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FBW_CMD_READ  = 2'h0,
        FBW_CMD_WRITE = 2'h1,
        FBW_CMD_SERASE = 2'h2,
        FBW_CMD_CERASE = 2'h3
    } fbw_cmd_t;

    typedef struct packed {
        logic              chip_sel_n;
        logic              out_drv_n;
        logic              wr_strobe_n;
        logic              programming_level;
        logic [ADDR_W-1:0] byte_addr;
    } fbw_pins_t;

endpackage

// ---- verification/fbw_flash_model.sv ----
`timescale 1ns/10ps
module fbw_flash_model import fbw_pkg::*; #(
    parameter int ABORT_NS = 400,
    parameter int BUSY_NS  = 400,
    parameter int ACC_NS   = 250
) (
    input  wire fbw_pins_t         pins,
    input  wire logic [DATA_W-1:0] bus,
    output logic [DATA_W-1:0]      dev_q,
    output int                     viol
);
    // ------------------------------------------------------------
    // Array and latches
    // ------------------------------------------------------------
    // byte array
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] last;
    logic              wr_on, sel_chip, pend, cut;
    realtime           t_fall, t_busy;
    wire               rd;

    initial begin
        viol = 0;
        wr_on = 1'b0;
        sel_chip = 1'b0;
        pend = 1'b0;
        cut = 1'b0;
        t_busy = 0;
        last = 8'h00;
        for (int i = 0; i < 2**ADDR_W; i++) mem[i] = ERASE_BYTE;
    end

    assign rd = !pins.chip_sel_n && !pins.out_drv_n && pins.wr_strobe_n;
    // Deselected lines show the inverse so a stale byte never passes
    assign #(ACC_NS) dev_q = rd ? mem[pins.byte_addr] : ~last;
    always @(dev_q) if (rd) last = dev_q;

    always @(negedge pins.wr_strobe_n or negedge pins.chip_sel_n) begin
        if (!pins.wr_strobe_n && !pins.chip_sel_n && pins.out_drv_n) begin
            wr_on = 1'b1;
            t_fall = $realtime;
            addr_reg = pins.byte_addr;
        end
    end

    always @(posedge pins.wr_strobe_n or posedge pins.chip_sel_n) begin
        if (wr_on) begin
            wr_on = 1'b0;
            if ($realtime - t_fall >= GLITCH_NS) do_write(bus);
        end
    end

    task automatic do_write(input logic [DATA_W-1:0] d);
        if (!pins.programming_level) begin
            sel_chip = 1'b1;
        end else if (pend) begin
            cut = 1'b1;
        end else if ($realtime < t_busy) begin
            viol++;
        end else if (d == ERASE_BYTE && sel_chip) begin
            for (int i = 0; i < 2**ADDR_W; i++) mem[i] = ERASE_BYTE;
            sel_chip = 1'b0;
        end else if (d == ERASE_BYTE) begin
            pend = 1'b1;
            cut = 1'b0;
            fork
                sector_erase(addr_reg[ADDR_W-1:COL_W]);
            join_none
        end else begin
            mem[addr_reg] = mem[addr_reg] & d;
            t_busy = $realtime + BUSY_NS;
        end
    endtask

    task automatic sector_erase(input logic [ADDR_W-COL_W-1:0] s);
        #(ABORT_NS);
        if (!cut) for (int i = 0; i < SECTOR_BYTES; i++) mem[{s, i[COL_W-1:0]}] = ERASE_BYTE;
        pend = 1'b0;
    endtask
endmodule // fbw_flash_model

// ---- verification/test_flash_byte_write_sector_erase_port.sv ----
`timescale 1ns/10ps
module test_flash_byte_write_sector_erase_port import fbw_pkg::*;;
    // ------------------------------------------------------------
    // Bench wiring
    // ------------------------------------------------------------
    logic              clk, rst, req_valid, abort_req;
    logic              req_ready, rsp_valid, rsp_aborted, byte_data_oe;
    fbw_cmd_t          req_cmd;
    fbw_pins_t         pins;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_data, rsp_data, byte_data_o, dev_q, bus;
    int                error_cnt, checked, viol, cyc;

    assign bus = byte_data_oe ? byte_data_o : dev_q;

    fbw_host #(.ABORT_CYCLES(20), .WC_CYCLES(30), .ERASE_CYCLES(50), .VPS_CYCLES(5)) u_dut (
        .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_cmd(req_cmd), .req_addr(req_addr), .req_data(req_data),
        .abort_req(abort_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_aborted(rsp_aborted), .pins(pins), .byte_data_o(byte_data_o),
        .byte_data_oe(byte_data_oe), .byte_data_i(bus));

    // Window matches 20 host cycles of 20 ns
    fbw_flash_model #(.ABORT_NS(400)) u_flash (
        .pins(pins), .bus(bus), .dev_q(dev_q), .viol(viol));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t ns: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask

    task automatic op(input fbw_cmd_t c, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
        @(negedge clk);
        req_cmd = c;
        req_addr = a;
        req_data = d;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        cyc = 1;
        while (rsp_valid !== 1'b1 && cyc < 3000) begin
            @(negedge clk);
            cyc++;
        end
        check(rsp_valid, 1'b1);
        @(negedge clk);
        check(rsp_valid, 1'b0);
    endtask

    task automatic t_idle;
        check(pins.wr_strobe_n, 1'b1);
        check(pins.programming_level, 1'b0);
        check(req_ready, 1'b1);
    endtask

    task automatic t_rw;
        op(FBW_CMD_WRITE, 17'h00c05, 8'h5a);
        op(FBW_CMD_READ, 17'h00c05, 8'h00);
        check(cyc, 17);
        check(rsp_data, 8'h5a);
        op(FBW_CMD_WRITE, 17'h00c05, 8'h0f);
        op(FBW_CMD_READ, 17'h00c05, 8'h00);
        check(rsp_data, 8'h0a);
        op(FBW_CMD_WRITE, 17'h1ffff, 8'h3c);
        op(FBW_CMD_READ, 17'h1ffff, 8'h00);
        check(rsp_data, 8'h3c);
    endtask

    task automatic t_ff;
        op(FBW_CMD_WRITE, 17'h00c05, 8'hff);
        check(cyc, 1);
        op(FBW_CMD_READ, 17'h00c05, 8'h00);
        check(rsp_data, 8'h0a);
    endtask

    task automatic t_sector;
        op(FBW_CMD_WRITE, 17'h01400, 8'h00);
        op(FBW_CMD_WRITE, 17'h017ff, 8'h00);
        op(FBW_CMD_WRITE, 17'h01800, 8'h00);
        op(FBW_CMD_SERASE, 17'h015a3, 8'hff);
        check(rsp_aborted, 1'b0);
        op(FBW_CMD_READ, 17'h01400, 8'h00);
        check(rsp_data, 8'hff);
        op(FBW_CMD_READ, 17'h017ff, 8'h00);
        check(rsp_data, 8'hff);
        op(FBW_CMD_READ, 17'h01800, 8'h00);
        check(rsp_data, 8'h00);
    endtask

    task automatic t_abort;
        op(FBW_CMD_WRITE, 17'h02000, 8'h11);
        abort_req = 1'b1;
        op(FBW_CMD_SERASE, 17'h02000, 8'hff);
        abort_req = 1'b0;
        check(rsp_aborted, 1'b1);
        op(FBW_CMD_READ, 17'h02000, 8'h00);
        check(rsp_data, 8'h11);
    endtask

    task automatic t_chip;
        logic [ADDR_W-1:0] al [3] = '{17'h00c05, 17'h1ffff, 17'h01800};
        op(FBW_CMD_CERASE, 17'h00000, 8'hff);
        foreach (al[i]) begin
            op(FBW_CMD_READ, al[i], 8'h00);
            check(rsp_data, 8'hff);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Whole run needs about a thousand cycles; this leaves ample margin
    initial begin
        #200000;
        error_cnt++;
        stop_test();
    end

    initial begin
        error_cnt = 0;
        checked = 0;
        rst = 1'b1;
        req_valid = 1'b0;
        abort_req = 1'b0;
        req_cmd = FBW_CMD_READ;
        req_addr = 17'h00000;
        req_data = 8'h00;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_idle();
        t_rw();
        t_ff();
        t_sector();
        t_abort();
        t_chip();
        check(viol, 0);
        stop_test();
    end
endmodule // test_flash_byte_write_sector_erase_port
